// file: hw/vsf_trip.sv
// vector surge and frequency trip element with ahb-lite register slave
//
// The register offsets and the AHB-Lite register port were decided locally.
`timescale 1ns/1ps

// Functional notes
// - Time every voltage cycle, restarting the count at each zero crossing.
// - Deviation of cycle time from reference period is the surge angle.
// - Surge above threshold trips at once, without any delay.
// - Loss of one or more phases inhibits surge tripping.
// - All three line voltages below lockout threshold block frequency and surge.
// - Low-voltage lockout acts no later than the surge result.
// - In surge mode compare against surge threshold, not frequency thresholds.
// - Select all, two or one phase; alarm and trip assert together unblocked.
// - Mains failure by vector surge trips within 60 ms.
// - Slow frequency drift must not trip; only abrupt deviations count.
// - Overfrequency releases only below 99.95 % of trip or 0.05 % nominal.
// - Underfrequency releases only above 100.05 % of trip or 0.05 % nominal.
// - Gradient stage trips once the configured delay has elapsed.
// - Under plus negative gradient mode trips after delay when both hold.
// - Over plus gradient mode trips after delay when both hold.
// - Gradient pickup alarms at once; trip only if still true at expiry.
module vsf_trip
  import vsf_pkg::*;
#(
  parameter int MS_CYCLES = VSF_MS_CYC_DFLT,
  parameter int PERIOD_TIMEOUT_CYC = VSF_TIMEOUT_CYC_DFLT
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic smp_valid,
  input wire vsf_volt_t volt,
  input wire logic [15:0] freq_meas,
  input wire logic signed [15:0] grad_meas,
  input wire logic block_in,
  output logic alarm,
  output logic trip,
  output logic surge_trip,
  output logic irq
);

  vsf_state_t st;
  vsf_state_t n;
  logic signed [2:0][15:0] v;
  logic [2:0] zc;
  logic [2:0][15:0] mag;
  logic [2:0][VSF_PER_W-1:0] dev;
  logic surge_go;
  logic [15:0] hyst_hi;
  logic [15:0] hyst_lo;
  logic over_hold;
  logic under_hold;

  assign v = {volt.line_voltage_c_a, volt.line_voltage_b_c,
              volt.line_voltage_a_b};

  // ----------------------------------------------------------------
  // per phase crossing, magnitude and deviation
  // ----------------------------------------------------------------
  // a crossing is a negative to non-negative sample step
  for (genvar i = 0; i < 3; i++) begin : g_phase
    assign zc[i] = smp_valid & st.prev_neg[i] & ~v[i][15];
    assign mag[i] = v[i][15] ? 16'(-v[i]) : 16'(v[i]);
    // cycle deviation from the previous period is the surge angle
    assign dev[i] = (st.per_cnt[i] > st.ref_per[i]) ?
                    st.per_cnt[i] - st.ref_per[i] :
                    st.ref_per[i] - st.per_cnt[i];
  end

  // hysteresis is the larger of 0.05 % of setting and of nominal
  always_comb begin
    hyst_hi = (st.f_hi > st.nominal) ? st.f_hi / VSF_HYST_DIV :
              st.nominal / VSF_HYST_DIV;
    hyst_lo = (st.f_lo > st.nominal) ? st.f_lo / VSF_HYST_DIV :
              st.nominal / VSF_HYST_DIV;
  end

  // held pickup only drops once frequency leaves the hysteresis band
  assign over_hold = ({1'b0, freq_meas} + {1'b0, hyst_hi}) >=
                     {1'b0, st.f_hi};
  assign under_hold = {1'b0, freq_meas} <=
                      ({1'b0, st.f_lo} + {1'b0, hyst_lo});

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [VSF_ST_W-1:0] clr;
    logic [VSF_ST_W-1:0] ev;
    logic [2:0] hit;
    logic [1:0] cnt;
    logic [1:0] need;
    logic live_i;
    logic blocked;
    logic over_c;
    logic under_c;
    logic grad_c;
    logic cond;
    clr = '0;
    ev = '0;
    hit = '0;
    cnt = '0;
    need = '0;
    live_i = 1'b0;
    blocked = 1'b0;
    over_c = 1'b0;
    under_c = 1'b0;
    grad_c = 1'b0;
    cond = 1'b0;
    surge_go = 1'b0;
    n = st;

    // bus: writes take no wait, reads one wait state
    n.wr_pend = 1'b0;
    n.rd_pend = 1'b0;
    n.hready = 1'b1;
    n.hresp = 1'b0;
    if (hsel && htrans[1] && hready) begin
      n.addr = haddr[5:2];
      n.wr_pend = hwrite;
      n.rd_pend = ~hwrite;
      n.hready = hwrite;
    end
    if (st.wr_pend) begin
      unique case (st.addr)
        VSF_R_CTRL: begin
          n.mode = vsf_mode_t'(hwdata[2:0]);
          n.phase_sel = hwdata[VSF_CTRL_SEL_LSB +: 2];
          n.soft_block = hwdata[VSF_CTRL_BLOCK];
        end
        VSF_R_SURGE_THR: n.surge_thr = hwdata[VSF_PER_W-1:0];
        VSF_R_UV_THR: n.uv_thr = hwdata[15:0];
        VSF_R_FREQ_HI: n.f_hi = hwdata[15:0];
        VSF_R_FREQ_LO: n.f_lo = hwdata[15:0];
        VSF_R_GRAD: n.grad_set = hwdata[15:0];
        VSF_R_DELAY: n.delay_ms = hwdata[15:0];
        VSF_R_NOMINAL: n.nominal = hwdata[15:0];
        VSF_R_STATUS: clr = hwdata[VSF_ST_W-1:0];
        VSF_R_MASK: n.mask = hwdata[VSF_ST_W-1:0];
        default: ;
      endcase
    end
    // read data is taken after the preceding write has landed
    if (st.rd_pend) begin
      case (st.addr)
        VSF_R_CTRL: n.hrdata = {23'h0, st.soft_block, 2'h0, st.phase_sel,
                                1'b0, st.mode};
        VSF_R_SURGE_THR: n.hrdata = {8'h0, st.surge_thr};
        VSF_R_UV_THR: n.hrdata = {16'h0, st.uv_thr};
        VSF_R_FREQ_HI: n.hrdata = {16'h0, st.f_hi};
        VSF_R_FREQ_LO: n.hrdata = {16'h0, st.f_lo};
        VSF_R_GRAD: n.hrdata = {16'h0, st.grad_set};
        VSF_R_DELAY: n.hrdata = {16'h0, st.delay_ms};
        VSF_R_NOMINAL: n.hrdata = {16'h0, st.nominal};
        VSF_R_STATUS: n.hrdata = {27'h0, st.status};
        VSF_R_MASK: n.hrdata = {27'h0, st.mask};
        VSF_R_LIVE: n.hrdata = {21'h0, st.live, st.ref_ok, st.pickup,
                                st.freq_trip, st.surge_latch, st.lockout,
                                st.ploss};
        VSF_R_DEV: n.hrdata = {8'h0, st.last_dev};
        default: n.hrdata = 32'h0;
      endcase
    end

    // per phase cycle timing, magnitude and surge hit
    for (int i = 0; i < 3; i++) begin
      if (smp_valid) begin
        n.prev_neg[i] = v[i][15];
        if (mag[i] > st.peak[i]) begin
          n.peak[i] = mag[i];
        end
      end
      if (st.per_cnt[i] != VSF_PER_MAX) begin
        n.per_cnt[i] = st.per_cnt[i] + 24'h1;
      end
      if (zc[i]) begin
        // the lockout decision uses the same cycle as the surge result
        live_i = st.peak[i] >= st.uv_thr;
        n.live[i] = live_i;
        n.ref_ok[i] = live_i & st.live[i];
        n.ref_per[i] = st.per_cnt[i];
        n.per_cnt[i] = '0;
        n.peak[i] = '0;
        hit[i] = st.ref_ok[i] & live_i & (dev[i] > st.surge_thr);
        if (hit[i]) begin
          n.last_dev = dev[i];
        end
      end else if (st.per_cnt[i] >= VSF_PER_W'(PERIOD_TIMEOUT_CYC)) begin
        // no crossing at all: the phase is gone
        n.live[i] = 1'b0;
        n.ref_ok[i] = 1'b0;
      end
      // a hit stays counted for one period so phases can coincide
      if (hit[i]) begin
        n.hold[i] = st.per_cnt[i];
      end else if (!n.live[i]) begin
        n.hold[i] = '0;
      end else if (st.hold[i] != '0) begin
        n.hold[i] = st.hold[i] - 24'h1;
      end
      cnt = cnt + {1'b0, n.hold[i] != '0};
    end

    n.lockout = ~|n.live;
    n.ploss = |n.live & ~&n.live;
    blocked = n.lockout | st.soft_block | block_in;

    // surge trip: instant, gated by lockout, phase loss and blocking
    need = (st.phase_sel == VSF_SEL_ALL) ? 2'h3 :
           (st.phase_sel == VSF_SEL_TWO) ? 2'h2 : 2'h1;
    surge_go = (st.mode == VSF_M_SURGE) && (cnt >= need) && !blocked &&
               !n.ploss;
    n.surge_latch = surge_go | (st.surge_latch & ~clr[VSF_EV_SURGE]);

    // frequency stage conditions
    over_c = st.pickup ? over_hold : (freq_meas >= st.f_hi);
    under_c = st.pickup ? under_hold : (freq_meas <= st.f_lo);
    grad_c = st.grad_set[15] ? (grad_meas <= st.grad_set) :
             (grad_meas >= st.grad_set);
    case (st.mode)
      VSF_M_OVER: cond = over_c;
      VSF_M_UNDER: cond = under_c;
      VSF_M_GRAD: cond = grad_c;
      VSF_M_UNDER_GRAD: cond = under_c & (grad_meas <= st.grad_set);
      VSF_M_OVER_GRAD: cond = over_c & (grad_meas >= st.grad_set);
      default: cond = 1'b0;
    endcase
    n.pickup = cond & ~blocked;

    // delay timer runs while picked up; dropping restarts it
    if (!n.pickup) begin
      n.ms_cnt = '0;
      n.elapsed = '0;
      n.freq_trip = 1'b0;
    end else begin
      if (st.ms_cnt >= VSF_MS_W'(MS_CYCLES - 1)) begin
        n.ms_cnt = '0;
        if (st.elapsed != 16'hFFFF) begin
          n.elapsed = st.elapsed + 16'h1;
        end
      end else begin
        n.ms_cnt = st.ms_cnt + 18'h1;
      end
      n.freq_trip = st.elapsed >= st.delay_ms;
    end

    // sticky events, set wins over the write-one clear
    ev[VSF_EV_SURGE] = surge_go;
    ev[VSF_EV_FALARM] = n.pickup & ~st.pickup;
    ev[VSF_EV_FTRIP] = n.freq_trip & ~st.freq_trip;
    ev[VSF_EV_LOCK] = n.lockout & ~st.lockout;
    ev[VSF_EV_PLOSS] = n.ploss & ~st.ploss;
    n.status = (st.status & ~clr) | ev;
    n.irq = |(n.status & n.mask);

    n.alarm = n.pickup | n.surge_latch;
    n.trip = n.freq_trip | n.surge_latch;
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  // lockout starts set since no phase has been seen live yet
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
      st.hready <= 1'b1;
      st.lockout <= 1'b1;
    end else begin
      st <= n;
    end
  end

  assign hreadyout = st.hready;
  assign hresp = st.hresp;
  assign hrdata = st.hrdata;
  assign alarm = st.alarm;
  assign trip = st.trip;
  assign surge_trip = st.surge_latch;
  assign irq = st.irq;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  surge_instant_a: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    surge_go |=> st.surge_latch && st.alarm && st.trip)
    else $error("surge did not trip alarm and trip next cycle");

  surge_gate_a: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    $rose(st.surge_latch) |-> (&st.live) && !st.ploss && !st.lockout)
    else $error("surge trip raised with a phase low");

  lock_block_a: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    st.lockout |-> !st.pickup && !$rose(st.surge_latch))
    else $error("stage active during low voltage lockout");

  period_restart_a: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    zc[0] |=> st.per_cnt[0] == '0 ##1 st.per_cnt[0] == 24'h1 || zc[0])
    else $error("cycle count not restarted at crossing");

  ref_follow_a: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    zc[1] |=> st.ref_per[1] == $past(st.per_cnt[1]))
    else $error("reference period does not follow last cycle");

  delay_trip_a: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    $rose(st.freq_trip) |-> st.pickup && $past(st.elapsed) >= st.delay_ms)
    else $error("frequency trip before delay expired");

  trip_drop_a: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    !st.pickup |-> !st.freq_trip && st.elapsed == '0)
    else $error("frequency trip held without pickup");

  over_hyst_a: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    st.pickup && st.mode == VSF_M_OVER && over_hold && !block_in &&
    !st.soft_block && !$rose(st.lockout) ##1 !st.lockout |-> st.pickup)
    else $error("overfrequency released inside hysteresis");

  // a write never waits, a read waits exactly one cycle
  write_nowait_a: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    hsel && htrans[1] && hready && hwrite |=> st.hready)
    else $error("write data phase inserted a wait state");

  read_wait_a: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    hsel && htrans[1] && hready && !hwrite |=> !st.hready ##1 st.hready)
    else $error("read data phase not one wait state");

  ploss_gate_a: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    st.ploss |-> !st.lockout && !$rose(st.surge_latch))
    else $error("surge trip raised during phase loss");

  surge_mode_a: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    $rose(st.surge_latch) |-> $past(st.mode) == VSF_M_SURGE)
    else $error("surge trip raised outside surge mode");

  block_pin_a: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    block_in |=> !st.pickup && !$rose(st.surge_latch))
    else $error("stage active under blocking command");

  alarm_instant_a: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    $rose(st.pickup) |-> st.alarm)
    else $error("pickup did not raise the alarm at once");

  irq_level_a: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    ##1 st.irq == |(st.status & st.mask))
    else $error("interrupt does not follow masked status");

endmodule

// file: include/vsf_pkg.sv
// constants, types and register map of the vector surge / frequency trip
package vsf_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int VSF_CLK_NS = 5;
  localparam int VSF_MS_NS = 1000000;
  localparam int VSF_MS_CYC_DFLT = VSF_MS_NS / VSF_CLK_NS;
  localparam int VSF_TIMEOUT_MS = 30;
  localparam int VSF_TIMEOUT_CYC_DFLT = VSF_TIMEOUT_MS * VSF_MS_CYC_DFLT;
  localparam int VSF_PER_W = 24;
  localparam int VSF_MS_W = 18;
  localparam logic [VSF_PER_W-1:0] VSF_PER_MAX = 24'hFFFFFF;
  localparam logic [15:0] VSF_HYST_DIV = 16'h07D0;  // 1/2000 = 0.05 %

  // ----------------------------------------------------------------
  // register word indices (byte address = index * 4)
  // ----------------------------------------------------------------
  localparam logic [3:0] VSF_R_CTRL = 4'h0;
  localparam logic [3:0] VSF_R_SURGE_THR = 4'h1;
  localparam logic [3:0] VSF_R_UV_THR = 4'h2;
  localparam logic [3:0] VSF_R_FREQ_HI = 4'h3;
  localparam logic [3:0] VSF_R_FREQ_LO = 4'h4;
  localparam logic [3:0] VSF_R_GRAD = 4'h5;
  localparam logic [3:0] VSF_R_DELAY = 4'h6;
  localparam logic [3:0] VSF_R_NOMINAL = 4'h7;
  localparam logic [3:0] VSF_R_STATUS = 4'h8;
  localparam logic [3:0] VSF_R_MASK = 4'h9;
  localparam logic [3:0] VSF_R_LIVE = 4'hA;
  localparam logic [3:0] VSF_R_DEV = 4'hB;

  // control field positions
  localparam int VSF_CTRL_SEL_LSB = 4;
  localparam int VSF_CTRL_BLOCK = 8;

  // status / mask bit positions
  localparam int VSF_ST_W = 5;
  localparam int VSF_EV_SURGE = 0;
  localparam int VSF_EV_FALARM = 1;
  localparam int VSF_EV_FTRIP = 2;
  localparam int VSF_EV_LOCK = 3;
  localparam int VSF_EV_PLOSS = 4;

  // phase count selection
  localparam logic [1:0] VSF_SEL_ALL = 2'h0;
  localparam logic [1:0] VSF_SEL_TWO = 2'h1;

  typedef enum logic [2:0] {
    VSF_M_OVER, VSF_M_UNDER, VSF_M_GRAD,
    VSF_M_UNDER_GRAD, VSF_M_OVER_GRAD, VSF_M_SURGE
  } vsf_mode_t;

  // three line voltage samples from the front end
  typedef struct packed {
    logic signed [15:0] line_voltage_c_a;
    logic signed [15:0] line_voltage_b_c;
    logic signed [15:0] line_voltage_a_b;
  } vsf_volt_t;

  typedef struct packed {
    logic [3:0] addr;
    logic wr_pend;
    logic rd_pend;
    logic hready;
    logic hresp;
    logic [31:0] hrdata;
    vsf_mode_t mode;
    logic [1:0] phase_sel;
    logic soft_block;
    logic [VSF_PER_W-1:0] surge_thr;
    logic [15:0] uv_thr;
    logic [15:0] f_hi;
    logic [15:0] f_lo;
    logic signed [15:0] grad_set;
    logic [15:0] delay_ms;
    logic [15:0] nominal;
    logic [VSF_ST_W-1:0] status;
    logic [VSF_ST_W-1:0] mask;
    logic [2:0] prev_neg;
    logic [2:0][VSF_PER_W-1:0] per_cnt;
    logic [2:0][VSF_PER_W-1:0] ref_per;
    logic [2:0] ref_ok;
    logic [2:0][15:0] peak;
    logic [2:0] live;
    logic [2:0][VSF_PER_W-1:0] hold;
    logic [VSF_PER_W-1:0] last_dev;
    logic lockout;
    logic ploss;
    logic pickup;
    logic [VSF_MS_W-1:0] ms_cnt;
    logic [15:0] elapsed;
    logic freq_trip;
    logic surge_latch;
    logic alarm;
    logic trip;
    logic irq;
  } vsf_state_t;

endpackage

// file: testbench/vsf_front_model.sv
// three-phase line voltage front end model for the surge bench
`timescale 1ns/1ps
// ----------------------------------------------------------------
// square waves, one half-period counter per phase
// ----------------------------------------------------------------
module vsf_front_model
  import vsf_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [15:0] half_cyc,
  input wire logic [2:0][15:0] amp,
  input wire logic [2:0] jump,
  output logic smp_valid,
  output vsf_volt_t volt
);
  logic [2:0][15:0] cnt;
  logic [2:0] neg;
  logic [2:0][15:0] v;
  logic [2:0] jpend;
  logic [2:0] land;

  // a jump waits for the next half start so the skip is always exact
  always_comb begin
    for (int p = 0; p < 3; p++) begin
      land[p] = jpend[p] && cnt[p] == 16'h0000;
    end
  end

  // a landed jump skips half of a half-period, one crossing comes early
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= '0;
      neg <= 3'h7;
      jpend <= 3'h0;
      smp_valid <= 1'b0;
    end else begin
      smp_valid <= ~smp_valid;
      for (int p = 0; p < 3; p++) begin
        if (cnt[p] >= half_cyc - 16'h0001) begin
          cnt[p] <= 16'h0000;
          neg[p] <= ~neg[p];
        end else if (land[p]) begin
          cnt[p] <= 16'h0001 + (half_cyc >> 1);
        end else begin
          cnt[p] <= cnt[p] + 16'h0001;
        end
      end
      jpend <= (jpend & ~land) | jump;
    end
  end

  // between strobes the lines show the inverse, never a stale sample
  always_comb begin
    for (int p = 0; p < 3; p++) begin
      v[p] = neg[p] ? 16'h0000 - amp[p] : amp[p];
      if (!smp_valid) begin
        v[p] = ~v[p];
      end
    end
  end
  assign volt = v;
endmodule

// file: testbench/tb_vsf_trip.sv
// self-checking bench for the surge and frequency trip element
`timescale 1ns/1ps
module tb_vsf_trip
  import vsf_pkg::*;
  ;
  // ----------------------------------------------------------------
  // signals and instances
  // ----------------------------------------------------------------
  localparam logic [31:0] ALL_EV = 32'h0000001F;
  localparam logic [47:0] FULL = {3{16'h03E8}};
  localparam logic [15:0] MID = 16'h4E20;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic block_in = 1'b0;
  logic [15:0] freq_meas = 16'h7530;
  logic [15:0] grad_meas = 16'h0000;
  logic [2:0][15:0] amp = '0;
  logic [2:0] jump = 3'h0;
  logic hreadyout, hresp, alarm, trip, surge_trip, irq, smp_valid;
  logic [31:0] hrdata, rd, outs;
  vsf_volt_t volt;
  int failures = 0;
  int cmp_count = 0;
  // per case: threshold, trip expected, pin block, jumped phases, control
  logic [21:0] scase [8] = '{22'hC6E05, 22'hC4205, 22'hC6615, 22'hC4215,
                             22'hC6825, 22'hC5E05, 22'hC4F05, 22'hC8E05};

  // 200 MHz reference clock
  always #2.5 ref_clk = ~ref_clk;
  assign outs = {28'h0, alarm, trip, surge_trip, irq};

  vsf_trip #(.MS_CYCLES(20), .PERIOD_TIMEOUT_CYC(2000)) vsf_trip_i (
    .ref_clk(ref_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .smp_valid(smp_valid), .volt(volt),
    .freq_meas(freq_meas), .grad_meas(grad_meas), .block_in(block_in),
    .alarm(alarm), .trip(trip), .surge_trip(surge_trip), .irq(irq));

  vsf_front_model vsf_front_model_i (
    .ref_clk(ref_clk), .rst_n(rst_n), .half_cyc(16'h0064), .amp(amp),
    .jump(jump), .smp_valid(smp_valid), .volt(volt));

  // ----------------------------------------------------------------
  // bus and check tasks
  // ----------------------------------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // waits for hready sampled high; only the watchdog ends a dead wait
  task automatic bus_wait();
    do begin
      @(posedge ref_clk);
    end while (hreadyout !== 1'b1);
  endtask

  task automatic ahb(input logic w, input logic [3:0] idx,
                     input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {26'h0, idx, 2'h0};
    hwrite <= w;
    htrans <= 2'h2;
    bus_wait();
    htrans <= 2'h0;
    hwdata <= d;
    bus_wait();
    rd = hrdata;
  endtask

  task automatic wr(input logic [3:0] idx, input logic [31:0] d);
    ahb(1'b1, idx, d);
  endtask

  task automatic rdc(input logic [3:0] idx, input logic [31:0] exp);
    ahb(1'b0, idx, 32'h0);
    chk(rd, exp);
    chk({31'h0, hresp}, 32'h0);
  endtask

  task automatic wait_surge(input int n);
    for (int i = 0; i < n && surge_trip !== 1'b1; i++) @(posedge ref_clk);
  endtask

  // short pickup must not trip, a held one trips after the delay
  task automatic freq_run(input logic [31:0] mode, input logic [31:0] gs,
                          input logic [15:0] f, input logic [15:0] g);
    wr(VSF_R_GRAD, gs);
    wr(VSF_R_CTRL, mode);
    freq_meas <= f;
    grad_meas <= g;
    cyc(12);
    freq_meas <= MID;
    grad_meas <= 16'h0000;
    cyc(80);
    chk(outs & 32'h4, 32'h0);
    freq_meas <= f;
    grad_meas <= g;
    cyc(3);
    chk(outs & 32'hC, 32'h8);
    cyc(15);
    chk(outs & 32'hC, 32'h8);
    cyc(45);
    chk(outs & 32'hC, 32'hC);
    freq_meas <= MID;
    grad_meas <= 16'h0000;
    cyc(3);
    chk(outs & 32'hC, 32'h0);
  endtask

  task automatic hyst_run(input logic [31:0] mode, input logic [15:0] fp,
                          input logic [15:0] fh, input logic [15:0] fr);
    wr(VSF_R_CTRL, mode);
    freq_meas <= fp;
    cyc(5);
    freq_meas <= fh;
    cyc(5);
    chk(outs & 32'h8, 32'h8);
    freq_meas <= fr;
    cyc(5);
    chk(outs & 32'h8, 32'h0);
    freq_meas <= MID;
    cyc(3);
  endtask

  task automatic conclude();
    if (failures == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  // a hang ends the run as a failure
  initial begin
    cyc(40000);
    failures++;
    conclude();
  end

  // main sequence: registers, surge cases, lockouts, frequency stages
  initial begin
    cyc(12);
    rst_n <= 1'b1;
    cyc(1);
    rdc(VSF_R_CTRL, 32'h0);
    wr(VSF_R_SURGE_THR, 32'h8);
    rdc(VSF_R_SURGE_THR, 32'h8);
    wr(4'hC, 32'hFFFFFFFF);
    rdc(4'hC, 32'h0);
    wr(VSF_R_UV_THR, 32'h64);
    wr(VSF_R_MASK, ALL_EV);
    rdc(VSF_R_MASK, ALL_EV);
    wr(VSF_R_CTRL, 32'h5);
    amp <= FULL;
    cyc(1200);
    wr(VSF_R_STATUS, ALL_EV);
    cyc(4);
    chk(outs, 32'h0);
    foreach (scase[k]) begin
      wr(VSF_R_SURGE_THR, {24'h0, scase[k][21:14]});
      wr(VSF_R_CTRL, {23'h0, scase[k][8:0]});
      block_in <= scase[k][12];
      jump <= scase[k][11:9];
      cyc(1);
      jump <= 3'h0;
      wait_surge(500);
      chk({31'h0, surge_trip}, {31'h0, scase[k][13]});
      if (scase[k][13]) begin
        chk(outs, 32'hF);
        rdc(VSF_R_DEV, 32'h32);
        wr(VSF_R_MASK, 32'h0);
        cyc(2);
        chk(outs, 32'hE);
        wr(VSF_R_MASK, ALL_EV);
      end
      cyc(800);
      block_in <= 1'b0;
      wr(VSF_R_STATUS, ALL_EV);
      cyc(3);
      chk(outs, 32'h0);
    end
    // one phase weak but still crossing: phase loss, surge held off
    wr(VSF_R_SURGE_THR, 32'h31);
    amp[2] <= 16'h0032;
    cyc(600);
    ahb(1'b0, VSF_R_LIVE, 32'h0);
    chk(rd & 32'h3, 32'h1);
    wr(VSF_R_CTRL, 32'h25);
    jump <= 3'h7;
    cyc(1);
    jump <= 3'h0;
    cyc(500);
    chk(outs & 32'hE, 32'h0);
    // all phases dead: lockout blocks the frequency stage as well
    amp <= '0;
    cyc(2600);
    ahb(1'b0, VSF_R_LIVE, 32'h0);
    chk(rd & 32'h3, 32'h2);
    wr(VSF_R_FREQ_HI, 32'h4E84);
    wr(VSF_R_CTRL, 32'h0);
    cyc(5);
    chk(outs & 32'hC, 32'h0);
    amp <= FULL;
    cyc(1200);
    chk(outs & 32'h8, 32'h8);
    freq_meas <= MID;
    wr(VSF_R_FREQ_LO, 32'h4DBC);
    wr(VSF_R_NOMINAL, 32'h4E20);
    wr(VSF_R_DELAY, 32'h2);
    wr(VSF_R_STATUS, ALL_EV);
    freq_run(32'h0, 32'h0, 16'h4EE8, 16'h0000);
    freq_run(32'h1, 32'h0, 16'h4D58, 16'h0000);
    freq_run(32'h2, 32'h64, MID, 16'h0096);
    freq_run(32'h3, 32'hFF9C, 16'h4D58, 16'hFF6A);
    freq_run(32'h4, 32'h64, 16'h4EE8, 16'h0096);
    freq_meas <= 16'h4EE8;
    cyc(5);
    chk(outs & 32'h8, 32'h0);
    freq_meas <= MID;
    wr(VSF_R_GRAD, 32'h0);
    hyst_run(32'h0, 16'h4EE8, 16'h4E7F, 16'h4E70);
    hyst_run(32'h1, 16'h4D58, 16'h4DC1, 16'h4DD0);
    conclude();
  end
endmodule
